/* dv/lsrc_chk.sv */
// port checker of the light sensor register block
`timescale 1ns/100ps
module lsrc_chk (
    input wire logic       clk,
    input wire logic       reset,
    input wire logic       scl,
    input wire logic       sda_out,
    input wire logic       sda_oe_n,
    input wire logic       alarm_out,
    input wire logic       alarm_oe_n,
    input wire logic       converter_run,
    input wire logic       converter_power_down,
    input wire logic [1:0] light_range,
    input wire logic       integration_start
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sda_drive_a: assert property (sda_out == 1'b0)
        else $error("data drive value not low");
    ack_phase_a: assert property ($fell(sda_oe_n) |-> !scl)
        else $error("data pulled low while bus clock high");
    sda_stable_a: assert property (scl && $past(scl)
        |-> $stable(sda_oe_n))
        else $error("data drive changed while bus clock high");
    alarm_drive_a: assert property (alarm_out == 1'b0)
        else $error("alarm drive value not low");
    run_pd_a: assert property (converter_run
        |-> !converter_power_down)
        else $error("converter runs while powered down");
    pd_quiet_a: assert property (converter_power_down
        && $past(converter_power_down, 3) |-> !integration_start)
        else $error("integration ended in power down");
    start_pulse_a: assert property (integration_start
        |=> !integration_start)
        else $error("integration start longer than one cycle");
    start_run_a: assert property (integration_start
        |-> converter_run || $past(converter_run))
        else $error("integration ended with core disabled");
    alarm_src_a: assert property ($fell(alarm_oe_n)
        |-> integration_start
        || $past(integration_start) || $past(integration_start, 2)
        || $past(integration_start, 3))
        else $error("alarm asserted without a new result");
    range_move_a: assert property (light_range != $past(light_range)
        |-> !scl)
        else $error("range changed outside a write");
endmodule : lsrc_chk

/* dv/lsrc_host.sv */
// serial bus host model for the register bus
`timescale 1ns/100ps
module lsrc_host (
    input  wire logic clk,
    input  wire logic sda_line,
    output logic      scl,
    output logic      sda_m
);
    int nacks = 0;
    initial
    begin
        scl = 1'b1;
        sda_m = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick
    // data moves only while the bus clock is low
    task automatic bit_io(input logic b, output logic r);
        sda_m <= b;
        tick(2);
        scl <= 1'b1;
        tick(3);
        r = sda_line;
        scl <= 1'b0;
        tick(2);
    endtask : bit_io
    task automatic start_c();
        @(posedge clk);
        sda_m <= 1'b1;
        tick(2);
        scl <= 1'b1;
        tick(3);
        sda_m <= 1'b0;
        tick(3);
        scl <= 1'b0;
        tick(2);
    endtask : start_c
    task automatic stop_c();
        sda_m <= 1'b0;
        tick(2);
        scl <= 1'b1;
        tick(3);
        sda_m <= 1'b1;
        tick(3);
    endtask : stop_c
    task automatic byte_io(input logic [7:0] d, input logic m,
                           output logic [7:0] q, output logic r);
        for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
        bit_io(m, r);
    endtask : byte_io
    task automatic wb(input logic [7:0] d);
        logic [7:0] q;
        logic       r;
        byte_io(d, 1'b1, q, r);
        if (r) nacks++;
    endtask : wb
    task automatic cmd(input logic [6:0] a, input logic [7:0] p);
        start_c();
        wb({a, 1'b0});
        wb(p);
        stop_c();
    endtask : cmd
    task automatic wr(input logic [6:0] a, input logic [7:0] p,
                      input logic [7:0] d);
        start_c();
        wb({a, 1'b0});
        wb(p);
        wb(d);
        stop_c();
    endtask : wr
    task automatic rd(input logic [6:0] a, input logic [7:0] p,
                      output logic [7:0] q);
        logic r;
        cmd(a, p);
        start_c();
        wb({a, 1'b1});
        byte_io(8'hFF, 1'b1, q, r);
        stop_c();
    endtask : rd
endmodule : lsrc_host

/* dv/tb_top.sv */
// self-checking bench of the light sensor register block
`timescale 1ns/100ps
module tb_top;
    import lsrc_pkg::*;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic        scl, sda_m, sda_out, sda_oe_n, alarm_out, alarm_oe_n;
    logic        pin_lo, pin_hi, run, pd, ir, start;
    logic [1:0]  rng;
    logic [15:0] ccount = 16'h0000;
    logic [15:0] seed;
    logic [6:0]  adr;
    wire         sda_w = sda_m & (sda_oe_n | sda_out);
    int          bad_count = 0;
    int          num_checks = 0;
    int          exp_reg [8] = '{8'h00, 8'h00, 8'hFF, 8'h00, 0, 0, 0, 0};

    always #5 clk = ~clk;

    lsrc_top lsrc_top_i (.clk(clk), .reset(reset), .scl(scl),
        .sda_in(sda_w), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
        .address_pin_low(pin_lo), .address_pin_high(pin_hi),
        .alarm_in(alarm_oe_n | alarm_out), .alarm_out(alarm_out),
        .alarm_oe_n(alarm_oe_n), .converter_count(ccount),
        .converter_run(run), .converter_power_down(pd),
        .infrared_photodiode_select(ir), .light_range(rng),
        .integration_start(start));
    lsrc_host lsrc_host_i (.clk(clk), .sda_line(sda_w), .scl(scl),
        .sda_m(sda_m));

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic results();
        if (bad_count == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : results
    task automatic wait_start(input int lim, output logic got);
        got = 1'b0;
        repeat (lim)
        begin
            @(negedge clk);
            if (start === 1'b1)
            begin
                got = 1'b1;
                break;
            end
        end
    endtask : wait_start

    initial
    begin
        repeat (60000) @(posedge clk);
        bad_count++;
        results();
    end

    initial
    begin
        logic [7:0] q;
        logic       got;
        seed = lfsr(16'h88E8);
        {pin_hi, pin_lo} <= seed[1:0];
        adr = {SLAVE_ADDR_HI, seed[1:0]};
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        for (int i = 0; i < 4; i++)
        begin
            lsrc_host_i.rd(adr, 8'(i), q);
            chk(q, 16'(exp_reg[i]));
        end
        lsrc_host_i.wr(adr, 8'h05, 8'hAA);
        lsrc_host_i.wr(adr ^ 7'h02, 8'h02, 8'h12);
        chk(16'(lsrc_host_i.nacks), 16'h0003);
        lsrc_host_i.wr(adr, 8'h01, 8'h0D);
        lsrc_host_i.wr(adr, 8'h02, 8'h00);
        exp_reg[1] = 8'h0D;
        exp_reg[2] = 8'h00;
        chk(rng, 16'h0003);
        seed = lfsr(seed);
        ccount <= seed | 16'h0001;
        lsrc_host_i.wr(adr, 8'h00, 8'h83);
        exp_reg[0] = 8'h83;
        chk({run, ir, pd}, 16'h0004);
        for (int k = 1; k <= 4; k++)
        begin
            wait_start(3000, got);
            repeat (5) @(negedge clk);
            chk({got, alarm_oe_n}, {1'b1, k < 4});
        end
        exp_reg[4] = (seed | 16'h0001) & 16'h000F;
        exp_reg[6] = 8'h10;
        exp_reg[1] = 8'h2D;
        for (int i = 0; i < 8; i++)
        begin
            lsrc_host_i.rd(adr, 8'(i), q);
            chk(q, 16'(exp_reg[i]));
        end
        wait_start(3000, got);
        lsrc_host_i.cmd(adr, 8'h40);
        chk(alarm_oe_n, 16'h0001);
        lsrc_host_i.rd(adr, 8'h01, q);
        chk(q, 16'h000D);
        wait_start(3000, got);
        chk(alarm_oe_n, 16'h0000);
        lsrc_host_i.wr(adr, 8'h01, 8'h0D);
        chk(alarm_oe_n, 16'h0001);
        lsrc_host_i.wr(adr, 8'h00, 8'hA7);
        chk(ir, 16'h0001);
        wait_start(2600, got);
        chk(got, 16'h0000);
        fork
            lsrc_host_i.cmd(adr, 8'h80);
            wait_start(1000, got);
        join
        chk(got, 16'h0001);
        ccount <= 16'h0007;
        lsrc_host_i.wr(adr, 8'h00, 8'hAB);
        lsrc_host_i.cmd(adr, 8'h80);
        chk(ir, 16'h0001);
        ccount <= 16'h0003;
        lsrc_host_i.cmd(adr, 8'h80);
        lsrc_host_i.rd(adr, 8'h04, q);
        chk(q, 16'h0002);
        lsrc_host_i.wr(adr, 8'h00, 8'hC3);
        chk({run, pd}, 16'h0001);
        wait_start(2600, got);
        chk(got, 16'h0000);
        lsrc_host_i.wr(adr, 8'h00, 8'h03);
        chk({run, pd}, 16'h0000);
        results();
    end
endmodule : tb_top

bind lsrc_top lsrc_chk lsrc_chk_i (.clk(clk), .reset(reset), .scl(scl),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .alarm_out(alarm_out),
    .alarm_oe_n(alarm_oe_n), .converter_run(converter_run),
    .converter_power_down(converter_power_down),
    .light_range(light_range), .integration_start(integration_start));

/* src/lsrc_i2c_slave.sv */
// serial slave that turns bus bytes into register traffic
`timescale 1ns/100ps
module lsrc_i2c_slave (
    input  wire logic               clk,
    input  wire logic               reset,
    input  wire logic               scl,
    input  wire logic               sda_in,
    input  wire logic [1:0]         addr_pins,
    input  wire logic [7:0]         rd_data,
    output logic                    sda_out,
    output logic                    sda_oe_n,
    output lsrc_pkg::lsrc_bus_t     bus
);
    import lsrc_pkg::*;

    typedef struct packed {
        lsrc_i2c_state_t st;
        logic            scl_p;
        logic            sda_p;
        logic [3:0]      bits;
        logic [7:0]      sh;
        logic [1:0]      idx;
        logic            rnw;
        logic            mack;
        logic            oe_n;
        logic            drv;
        lsrc_bus_t       bus;
    } lsrc_i2c_reg_t;

    lsrc_i2c_reg_t s_q;
    lsrc_i2c_reg_t s_d;
    logic          rise;
    logic          fall;
    logic          start;
    logic          stop;

    always_comb
    begin
        rise  = ~s_q.scl_p & scl;
        fall  = s_q.scl_p & ~scl;
        start = s_q.scl_p & scl & s_q.sda_p & ~sda_in;
        stop  = s_q.scl_p & scl & ~s_q.sda_p & sda_in;
        s_d   = s_q;
        s_d.scl_p       = scl;
        s_d.sda_p       = sda_in;
        s_d.bus.wr      = 1'b0;
        s_d.bus.restart = 1'b0;
        s_d.bus.clear   = 1'b0;
        if (start)
        begin
            s_d.st   = I2C_RECV;
            s_d.bits = 4'h0;
            s_d.idx  = 2'h0;
            s_d.oe_n = 1'b1;
        end
        else if (stop)
        begin
            s_d.st   = I2C_IDLE;
            s_d.oe_n = 1'b1;
        end
        else
        begin
            case (s_q.st)
                I2C_RECV:
                    if (rise)
                    begin
                        s_d.sh   = {s_q.sh[6:0], sda_in};
                        s_d.bits = 4'(s_q.bits + 4'h1);
                    end
                    else if (fall && s_q.bits == 4'h8)
                    begin
                        s_d.bits = 4'h0;
                        s_d.st   = I2C_ACK;
                        s_d.oe_n = 1'b0;
                        case (s_q.idx)
                            2'h0:
                                if (s_q.sh[7:1] == {SLAVE_ADDR_HI, addr_pins})
                                begin
                                    s_d.rnw = s_q.sh[0];
                                    s_d.idx = 2'h1;
                                end
                                else
                                begin
                                    s_d.st   = I2C_IDLE;
                                    s_d.oe_n = 1'b1;
                                end
                            2'h1:
                            begin
                                s_d.bus.ptr     = s_q.sh;
                                s_d.bus.restart = s_q.sh[ADDR_RESTART_BIT];
                                s_d.bus.clear   = s_q.sh[ADDR_CLEAR_BIT];
                                s_d.idx         = 2'h2;
                            end
                            default:
                            begin
                                // command addresses carry no data
                                s_d.bus.wr    = s_q.bus.ptr[7:6] == 2'h0;
                                s_d.bus.waddr = s_q.bus.ptr;
                                s_d.bus.wdata = s_q.sh;
                                s_d.bus.ptr   = 8'(s_q.bus.ptr + 8'h01);
                            end
                        endcase
                    end
                I2C_ACK:
                    if (fall)
                    begin
                        s_d.bits = 4'h0;
                        if (s_q.rnw)
                        begin
                            s_d.sh   = rd_data;
                            s_d.oe_n = rd_data[7];
                            s_d.st   = I2C_SEND;
                        end
                        else
                        begin
                            s_d.oe_n = 1'b1;
                            s_d.st   = I2C_RECV;
                        end
                    end
                I2C_SEND:
                    if (rise)
                        s_d.bits = 4'(s_q.bits + 4'h1);
                    else if (fall && s_q.bits == 4'h8)
                    begin
                        s_d.oe_n = 1'b1;
                        s_d.st   = I2C_RACK;
                    end
                    else if (fall)
                    begin
                        s_d.sh   = {s_q.sh[6:0], 1'b0};
                        s_d.oe_n = s_q.sh[6];
                    end
                I2C_RACK:
                    if (rise)
                    begin
                        s_d.mack = ~sda_in;
                        if (!sda_in)
                            s_d.bus.ptr = 8'(s_q.bus.ptr + 8'h01);
                    end
                    else if (fall && s_q.mack)
                    begin
                        s_d.sh   = rd_data;
                        s_d.oe_n = rd_data[7];
                        s_d.bits = 4'h0;
                        s_d.st   = I2C_SEND;
                    end
                    else if (fall)
                        s_d.st = I2C_IDLE;
                default:
                    s_d.st = I2C_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            s_q <= '{st: I2C_IDLE, scl_p: 1'b1, sda_p: 1'b1,
                     oe_n: 1'b1, default: '0};
        else
            s_q <= s_d;
    end

    assign sda_out  = s_q.drv;
    assign sda_oe_n = s_q.oe_n;
    assign bus      = s_q.bus;
endmodule : lsrc_i2c_slave

/* src/lsrc_pkg.sv */
// shared constants and carriers of the light sensor register block
package lsrc_pkg;
    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_HZ       = 100_000_000;
    localparam int OSC_SLOW_HZ  = 327_000;
    localparam int OSC_FAST_HZ  = 655_000;
    localparam int OSC_SLOW_DIV = CLK_HZ / OSC_SLOW_HZ;
    localparam int OSC_FAST_DIV = CLK_HZ / OSC_FAST_HZ;

    // ----------------------------------------------------------------
    // addressing
    // ----------------------------------------------------------------
    localparam logic [4:0] SLAVE_ADDR_HI = 5'h11;
    localparam logic [2:0] ADDR_CMD      = 3'h0;
    localparam logic [2:0] ADDR_CTL      = 3'h1;
    localparam logic [2:0] ADDR_THR_HI   = 3'h2;
    localparam logic [2:0] ADDR_THR_LO   = 3'h3;
    localparam logic [2:0] ADDR_RES_LO   = 3'h4;
    localparam logic [2:0] ADDR_RES_HI   = 3'h5;
    localparam logic [2:0] ADDR_TMR_LO   = 3'h6;
    localparam logic [2:0] ADDR_TMR_HI   = 3'h7;
    localparam int ADDR_RESTART_BIT = 7;
    localparam int ADDR_CLEAR_BIT   = 6;

    // ----------------------------------------------------------------
    // fields and reset values
    // ----------------------------------------------------------------
    localparam int CMD_ENABLE_BIT  = 7;
    localparam int CMD_PD_BIT      = 6;
    localparam int CMD_EXT_BIT     = 5;
    localparam int CMD_DIODE_LSB   = 2;
    localparam int CMD_WIDTH_LSB   = 0;
    localparam int CTL_FLAG_BIT    = 5;
    localparam int CTL_RANGE_LSB   = 2;
    localparam int CTL_PERSIST_LSB = 0;
    localparam logic [7:0] CMD_RESET    = 8'h00;
    localparam logic [7:0] CTL_RESET    = 8'h00;
    localparam logic [7:0] THR_HI_RESET = 8'hFF;
    localparam logic [7:0] THR_LO_RESET = 8'h00;

    localparam logic [16:0] WIDTH_CYC_0 = 17'h10000;
    localparam logic [16:0] WIDTH_CYC_1 = 17'h01000;
    localparam logic [16:0] WIDTH_CYC_2 = 17'h00100;
    localparam logic [16:0] WIDTH_CYC_3 = 17'h00010;
    localparam logic [4:0]  PERSIST_0   = 5'h01;
    localparam logic [4:0]  PERSIST_1   = 5'h04;
    localparam logic [4:0]  PERSIST_2   = 5'h08;
    localparam logic [4:0]  PERSIST_3   = 5'h10;

    localparam logic [1:0] DIODE_VISIBLE  = 2'h0;
    localparam logic [1:0] DIODE_INFRARED = 2'h1;
    localparam logic [1:0] DIODE_DIFF     = 2'h2;

    typedef enum logic [2:0] {
        I2C_IDLE, I2C_RECV, I2C_ACK, I2C_SEND, I2C_RACK
    } lsrc_i2c_state_t;

    // register traffic from the serial slave
    typedef struct packed {
        logic       wr;
        logic       restart;
        logic       clear;
        logic [7:0] waddr;
        logic [7:0] wdata;
        logic [7:0] ptr;
    } lsrc_bus_t;
endpackage : lsrc_pkg

/* src/lsrc_top.sv */
// register set and conversion control of the light sensor
`timescale 1ns/100ps
// Behaviour
// - command bit 7 low holds the conversion core in reset.
// - command bit 6 high powers the device down.
// - internal timing ends each integration after the programmed tick count.
// - external timing: integration spans restart command to restart command.
// - in external timing, address bit 7 write ends integration and starts the next.
// - address bit 6 write clears the alarm flag and output.
// - diode select 0 or 1 routes one diode, unsigned n-bit result.
// - diode select 2 gives signed difference; 3 does nothing.
// - command bits 1:0 pick 65536, 4096, 256 or 16 cycles.
// - in internal timing, cycle selection changes integration length as well as resolution.
// - control bit 5 reads 1 once the alarm has triggered.
// - control bits 3:2 select the light range.
// - control bits 1:0 pick 1, 4, 8 or 16 persistence cycles.
// - upper threshold is a high byte, resets to 0xFF.
// - lower threshold is a high byte, resets to 0x00.
// - locations 4 and 5 read the latest result; writes ignored.
// - locations 6 and 7 read the captured timer count.
// - writing 0 to flag clears it; window breach sets flag and pin.
// - timer counts oscillator cycles, captured at each integration end.
// - slave address is 10001 then the two address pins.
module lsrc_top (
    input  wire logic         clk,
    input  wire logic         reset,
    input  wire logic         scl,
    input  wire logic         sda_in,
    output logic              sda_out,
    output logic              sda_oe_n,
    input  wire logic         address_pin_low,
    input  wire logic         address_pin_high,
    input  wire logic         alarm_in,
    output logic              alarm_out,
    output logic              alarm_oe_n,
    input  wire logic [15:0]  converter_count,
    output logic              converter_run,
    output logic              converter_power_down,
    output logic              infrared_photodiode_select,
    output logic [1:0]        light_range,
    output logic              integration_start
);
    import lsrc_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  cmd;
        logic [7:0]  ctl;
        logic [7:0]  thr_hi;
        logic [7:0]  thr_lo;
        logic [15:0] result;
        logic [15:0] timer;
        logic [15:0] tmr_cnt;
        logic [16:0] integ;
        logic [8:0]  div;
        logic        phase;
        logic [15:0] hold;
        logic [4:0]  pcnt;
        logic        run;
        logic        pd;
        logic        ir_sel;
        logic [1:0]  range;
        logic        start;
        logic        alarm_oe_n;
        logic        alarm_o;
    } lsrc_state_t;

    lsrc_state_t s_q;
    lsrc_state_t s_d;
    lsrc_bus_t   bus;
    logic [7:0]  rd_data;
    logic        sda_out_w;
    logic        sda_oe_n_w;

    logic [8:0]  div_lim;
    logic        tick;
    logic [16:0] limit;
    logic [15:0] mask;
    logic [4:0]  persist_m;
    logic        end_int;
    logic        newres;
    logic [15:0] sample;
    logic [16:0] diff;
    logic        out_win;
    logic        ext_mode;
    logic [1:0]  diode;

    // ----------------------------------------------------------------
    // serial slave
    // ----------------------------------------------------------------
    // the slave only pulls data low
    lsrc_i2c_slave u_slave (
        .clk       (clk),
        .reset     (reset),
        .scl       (scl),
        .sda_in    (sda_in),
        .addr_pins ({address_pin_high, address_pin_low}),
        .rd_data   (rd_data),
        .sda_out   (sda_out_w),
        .sda_oe_n  (sda_oe_n_w),
        .bus       (bus)
    );

    // ----------------------------------------------------------------
    // read mux
    // ----------------------------------------------------------------
    always_comb
    begin
        rd_data = 8'h00;
        // unmapped pointers read zero
        if (bus.ptr[5:3] == 3'h0)
        begin
            case (bus.ptr[2:0])
                ADDR_CMD:    rd_data = s_q.cmd;
                ADDR_CTL:    rd_data = s_q.ctl;
                ADDR_THR_HI: rd_data = s_q.thr_hi;
                ADDR_THR_LO: rd_data = s_q.thr_lo;
                ADDR_RES_LO: rd_data = s_q.result[7:0];
                ADDR_RES_HI: rd_data = s_q.result[15:8];
                ADDR_TMR_LO: rd_data = s_q.timer[7:0];
                ADDR_TMR_HI: rd_data = s_q.timer[15:8];
                default:     rd_data = 8'h00;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb
    begin
        s_d      = s_q;
        s_d.start = 1'b0;
        ext_mode = s_q.cmd[CMD_EXT_BIT];
        diode    = s_q.cmd[CMD_DIODE_LSB +: 2];

        // oscillator runs twice as fast on the two upper ranges
        div_lim = s_q.ctl[CTL_RANGE_LSB + 1] ? 9'(OSC_FAST_DIV - 1)
                                             : 9'(OSC_SLOW_DIV - 1);
        case (s_q.cmd[CMD_WIDTH_LSB +: 2])
            2'h0:    limit = WIDTH_CYC_0;
            2'h1:    limit = WIDTH_CYC_1;
            2'h2:    limit = WIDTH_CYC_2;
            default: limit = WIDTH_CYC_3;
        endcase
        // keep the n chosen bits
        mask = 16'(limit - 17'h00001);

        case (s_q.ctl[CTL_PERSIST_LSB +: 2])
            2'h0:    persist_m = PERSIST_0;
            2'h1:    persist_m = PERSIST_1;
            2'h2:    persist_m = PERSIST_2;
            default: persist_m = PERSIST_3;
        endcase

        // register writes; factory bits are stored as the host writes
        if (bus.wr && bus.waddr[5:3] == 3'h0)
        begin
            case (bus.waddr[2:0])
                ADDR_CMD:    s_d.cmd = bus.wdata;
                ADDR_CTL:
                begin
                    s_d.ctl = bus.wdata;
                    // the flag cannot be set by software
                    s_d.ctl[CTL_FLAG_BIT] = s_q.ctl[CTL_FLAG_BIT]
                                          & bus.wdata[CTL_FLAG_BIT];
                end
                ADDR_THR_HI: s_d.thr_hi = bus.wdata;
                ADDR_THR_LO: s_d.thr_lo = bus.wdata;
                // data bytes read-only
                default:     s_d.cmd = s_q.cmd;
            endcase
        end

        // clear beats a flag write
        if (bus.clear)
            s_d.ctl[CTL_FLAG_BIT] = 1'b0;

        // conversion timing
        tick    = 1'b0;
        end_int = 1'b0;
        newres  = 1'b0;
        sample  = converter_count & mask;
        diff    = 17'({1'b0, s_q.hold} - {1'b0, sample});
        out_win = 1'b0;
        // disabled core clears counts
        if (!s_q.cmd[CMD_ENABLE_BIT])
        begin
            s_d.div     = 9'h000;
            s_d.integ   = 17'h00000;
            s_d.tmr_cnt = 16'h0000;
            s_d.phase   = 1'b0;
        end
        else if (!s_q.cmd[CMD_PD_BIT])
        begin
            // power down freezes counts;
            // a paused period resumes
            tick = s_q.div == div_lim;
            s_d.div = tick ? 9'h000 : 9'(s_q.div + 9'h001);
            if (tick)
            begin
                s_d.integ   = 17'(s_q.integ + 17'h00001);
                s_d.tmr_cnt = 16'(s_q.tmr_cnt + 16'h0001);
            end
            // no restart in internal timing
            if (ext_mode)
                end_int = bus.restart;
            else
                end_int = tick && s_q.integ == 17'(limit - 17'h00001);
        end

        if (end_int)
        begin
            // closing tick counts here
            s_d.timer   = s_d.tmr_cnt;
            s_d.integ   = 17'h00000;
            s_d.tmr_cnt = 16'h0000;
            s_d.start   = 1'b1;
            case (diode)
                DIODE_VISIBLE, DIODE_INFRARED:
                begin
                    s_d.result = sample;
                    newres     = 1'b1;
                end
                DIODE_DIFF:
                    if (!s_q.phase)
                    begin
                        s_d.hold  = sample;
                        s_d.phase = 1'b1;
                    end
                    else
                    begin
                        // halved so the signed result fits n bits
                        s_d.result = diff[16:1];
                        s_d.phase  = 1'b0;
                        newres     = 1'b1;
                    end
                // no-op keeps old result
                default:
                    s_d.phase = 1'b0;
            endcase
        end

        // window check against the high-byte thresholds
        if (newres)
        begin
            out_win = s_d.result > {s_q.thr_hi, 8'h00}
                   || s_d.result < {s_q.thr_lo, 8'h00};
            if (!out_win)
                s_d.pcnt = 5'h00;
            else
            begin
                // streak saturates at m, so
                // a clear re-alarms at once
                if (s_q.pcnt < persist_m)
                    s_d.pcnt = 5'(s_q.pcnt + 5'h01);

                // set wins over a clear in the same cycle
                if (5'(s_q.pcnt + 5'h01) >= persist_m)
                    s_d.ctl[CTL_FLAG_BIT] = 1'b1;
            end
        end

        // outputs
        s_d.run    = s_d.cmd[CMD_ENABLE_BIT] & ~s_d.cmd[CMD_PD_BIT];
        s_d.pd     = s_d.cmd[CMD_PD_BIT];
        s_d.ir_sel = s_d.cmd[CMD_DIODE_LSB +: 2] == DIODE_INFRARED
                  || (s_d.cmd[CMD_DIODE_LSB +: 2] == DIODE_DIFF
                      && s_d.phase);
        s_d.range  = s_d.ctl[CTL_RANGE_LSB +: 2];
        s_d.alarm_oe_n = ~s_d.ctl[CTL_FLAG_BIT];
        // open drain, pulled low only
        s_d.alarm_o    = 1'b0;
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            s_q <= '{cmd: CMD_RESET, ctl: CTL_RESET,
                     thr_hi: THR_HI_RESET, thr_lo: THR_LO_RESET,
                     alarm_oe_n: 1'b1, default: '0};
        else
            s_q <= s_d;
    end

    assign sda_out                    = sda_out_w;
    assign sda_oe_n                   = sda_oe_n_w;
    assign alarm_out                  = s_q.alarm_o;
    assign alarm_oe_n                 = s_q.alarm_oe_n;
    assign converter_run              = s_q.run;
    assign converter_power_down       = s_q.pd;
    assign infrared_photodiode_select = s_q.ir_sel;
    assign light_range                = s_q.range;
    assign integration_start          = s_q.start;
endmodule : lsrc_top
